// >>> logic/pbsc_defines.svh
// Constants shared by the pipelined burst memory control logic.
`ifndef PBSC_DEFINES_SVH
`define PBSC_DEFINES_SVH

// Address pins, burst counter width and the word layout.
`define PBSC_ADDR_W 18
`define PBSC_BURST_W 2
`define PBSC_DATA_W 32
`define PBSC_LANES 4
`define PBSC_WORD_W 36

// Word layout: data bytes in bits 31:0, one parity bit per lane in 35:32.
`define PBSC_PAR_LSB 32

// Lane masks for a write.
`define PBSC_ALL_LANES 4'hF
`define PBSC_NO_LANES 4'h0

// Sleep entry and exit each take this many clock cycles.
`define PBSC_SLEEP_TRANSITION_CYCLES 2
`define PBSC_SLEEP_CNT_W 2

// Burst order strap levels: low selects linear, high or floating interleaved.
`define PBSC_ORDER_LINEAR 1'h0
`define PBSC_ORDER_INTERLEAVED 1'h1

// Reset levels of the active-low synchronous pins and of the order strap.
`define PBSC_PIN_IDLE_N 1'h1
`define PBSC_SYNC_IDLE_HIGH 2'h3

`endif

// >>> logic/pbsc_pkg.sv
// Types of the pipelined burst memory control logic.
`include "pbsc_defines.svh"

package pbsc_pkg;

    // Phases of the low-power sleep sequence.
    typedef enum logic [1:0] {
        SLP_RUN,
        SLP_ENTER,
        SLP_ASLEEP,
        SLP_EXIT
    } pbsc_sleep_type;

    // Synchronous pins as captured by the input register.
    typedef struct packed {
        logic [`PBSC_ADDR_W-1:0] addr;
        logic cs1_n;
        logic cs2;
        logic cs3_n;
        logic pstb_n;
        logic cstb_n;
        logic advance_n;
        logic gwr_n;
        logic byte_wr_n;
        logic [`PBSC_LANES-1:0] lane_sel_n;
        logic [`PBSC_WORD_W-1:0] data;
    } pbsc_pins_type;

    // Whole state of the top module, apart from the burst counter's own registers.
    typedef struct packed {
        logic [1:0] oe_sync;
        logic [1:0] sleep_sync;
        logic [1:0] order_sync;
        pbsc_pins_type pins;
        logic active;
        logic rd_issue;
        logic [`PBSC_ADDR_W-1:0] arr_addr;
        logic [`PBSC_LANES-1:0] arr_we;
        logic [`PBSC_WORD_W-1:0] arr_wdata;
        logic [`PBSC_WORD_W-1:0] dout;
        logic dq_oe_n;
        pbsc_sleep_type sleep_st;
        logic [`PBSC_SLEEP_CNT_W-1:0] sleep_cnt;
        logic low_power;
    } pbsc_state_type;

    // State of the two-bit burst counter.
    typedef struct packed {
        logic [`PBSC_BURST_W-1:0] first;
        logic [`PBSC_BURST_W-1:0] cnt;
        logic [`PBSC_BURST_W-1:0] cur;
    } pbsc_burst_type;

endpackage

// >>> logic/pbsc_burst_counter.sv
// Two-bit wraparound burst counter with linear and interleaved order.
`timescale 1ns/1ps
`include "pbsc_defines.svh"

module pbsc_burst_counter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [`PBSC_BURST_W-1:0] load_bits,
    input wire logic step,
    input wire logic interleaved,
    output logic [`PBSC_BURST_W-1:0] cur,
    output logic [`PBSC_BURST_W-1:0] nxt
);

    pbsc_pkg::pbsc_burst_type st_q; // Registered counter state.
    pbsc_pkg::pbsc_burst_type st_d; // Next counter state.
    logic [`PBSC_BURST_W-1:0] cnt_inc; // Step count after one more advance.

    // The step count wraps modulo four, so a fourth advance returns to the start.
    assign cnt_inc = st_q.cnt + 2'h1;
    // Interleaved order flips bits of the start value, linear order adds one.
    assign nxt = interleaved ? (st_q.first ^ cnt_inc) : (st_q.cur + 2'h1);
    assign cur = st_q.cur;

    // Next state: a load restarts the sequence, a step walks it.
    always_comb begin
        st_d = st_q;
        if (load) begin
            st_d.first = load_bits;
            st_d.cnt = 2'h0;
            st_d.cur = load_bits;
        end else if (step) begin
            st_d.cnt = cnt_inc;
            st_d.cur = nxt;
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_interleave_step;
        (step && !load && interleaved) |=> cur == ($past(st_q.first) ^ ($past(st_q.cnt) + 2'h1));
    endproperty
    a_interleave_step: assert property (p_interleave_step) else $error("Interleaved step wrong.");

    property p_linear_step;
        (step && !load && !interleaved) |=> cur == $past(cur) + 2'h1;
    endproperty
    a_linear_step: assert property (p_linear_step) else $error("Linear step wrong.");

    property p_wrap;
        (step && !load && st_q.cnt == 2'h3) |=> cur == st_q.first && st_q.cnt == 2'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("Counter did not wrap to the first address.");

endmodule

// >>> logic/pbsc_top.sv
// Control logic of a pipelined burst static memory: pins, burst, writes, sleep.
`timescale 1ns/1ps
`include "pbsc_defines.svh"


module pbsc_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`PBSC_ADDR_W-1:0] addr,
    input wire logic chip_sel1_n,
    input wire logic chip_sel2,
    input wire logic chip_sel3_n,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic byte_write_enable_n,
    input wire logic [`PBSC_LANES-1:0] byte_lane_select_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic burst_order_sel,
    input wire logic [`PBSC_DATA_W-1:0] dq_i,
    output logic [`PBSC_DATA_W-1:0] dq_o,
    output logic dq_oe_n,
    input wire logic [`PBSC_LANES-1:0] parity_io_i,
    output logic [`PBSC_LANES-1:0] parity_io_o,
    output logic parity_io_oe_n,
    output logic [`PBSC_ADDR_W-1:0] arr_addr,
    output logic [`PBSC_LANES-1:0] arr_byte_we,
    output logic [`PBSC_WORD_W-1:0] arr_wdata,
    input wire logic [`PBSC_WORD_W-1:0] arr_rdata,
    output logic low_power
);

    pbsc_pkg::pbsc_state_type st_q; // Registered state.
    pbsc_pkg::pbsc_state_type st_d; // Next state.
    pbsc_pkg::pbsc_pins_type p; // Pins captured at the previous edge.

    logic awake; // Sleep sequence is idle, accesses are honoured.
    logic sel; // All three chip selects active.
    logic pstb_go; // Processor strobe recognised.
    logic cstb_go; // Controller strobe recognised.
    logic start; // Some strobe asks for a new access or a deselect.
    logic [`PBSC_LANES-1:0] lanes; // Byte lanes the write controls ask for.
    logic wr_ctl; // Write controls active.
    logic load; // New address enters address register and counter.
    logic step; // Burst counter advances this cycle.
    logic wr_go; // A write is issued to the array this cycle.
    logic rd_go; // A read is issued to the array this cycle.
    logic tristate_now; // This cycle forces the data pins off.
    logic interleaved; // Selected burst order.
    logic [`PBSC_BURST_W-1:0] burst_cur; // Current low address bits.
    logic [`PBSC_BURST_W-1:0] burst_nxt; // Low address bits after one step.

    assign p = st_q.pins;
    assign awake = (st_q.sleep_st == pbsc_pkg::SLP_RUN);
    assign interleaved = (st_q.order_sync[1] == `PBSC_ORDER_INTERLEAVED);
    assign sel = !p.cs1_n && p.cs2 && !p.cs3_n;

    // The processor strobe counts only while the first select is low.
    assign pstb_go = !p.pstb_n && !p.cs1_n;
    // When both strobes are recognised the controller strobe is dropped.
    assign cstb_go = !p.cstb_n && !pstb_go;
    assign start = pstb_go || cstb_go;

    // Global write overrides the byte controls; otherwise lanes come from the selects.
    assign lanes = !p.gwr_n ? `PBSC_ALL_LANES : (!p.byte_wr_n ? ~p.lane_sel_n : `PBSC_NO_LANES);
    assign wr_ctl = (lanes != `PBSC_NO_LANES);

    // Access decode. A processor strobe start is always a read; its write
    // happens on the following cycle as an ordinary continue cycle.
    always_comb begin
        load = 1'b0;
        step = 1'b0;
        wr_go = 1'b0;
        rd_go = 1'b0;
        if (!awake) begin
            // Sleep transitions and sleep itself ignore every pin.
        end else if (start && sel) begin
            load = 1'b1;
            if (cstb_go && wr_ctl) begin
                wr_go = 1'b1;
            end else begin
                rd_go = 1'b1;
            end
        end else if (!start && st_q.active) begin
            // Continue or suspend the burst; advance is read only here.
            step = !p.advance_n;
            if (wr_ctl) begin
                wr_go = 1'b1;
            end else begin
                rd_go = 1'b1;
            end
        end
    end

    // Cycles that drive the data pins off regardless of output enable.
    assign tristate_now = !awake || wr_go || (start && !sel)
                          || (start && sel && !st_q.active);

    pbsc_burst_counter i_pbsc_burst_counter (
        .clk(clk),
        .rst_n(rst_n),
        .load(load),
        .load_bits(p.addr[`PBSC_BURST_W-1:0]),
        .step(step),
        .interleaved(interleaved),
        .cur(burst_cur),
        .nxt(burst_nxt)
    );

    // Next-state logic for the pipeline, the pin drivers and the sleep sequence.
    always_comb begin
        st_d = st_q;
        // Asynchronous pins pass two flip-flops before anything reads them.
        st_d.oe_sync = {st_q.oe_sync[0], output_enable_n};
        st_d.sleep_sync = {st_q.sleep_sync[0], sleep_request};
        st_d.order_sync = {st_q.order_sync[0], burst_order_sel};
        // Synchronous pins are captured once on the rising edge.
        st_d.pins.addr = addr;
        st_d.pins.cs1_n = chip_sel1_n;
        st_d.pins.cs2 = chip_sel2;
        st_d.pins.cs3_n = chip_sel3_n;
        st_d.pins.pstb_n = processor_addr_strobe_n;
        st_d.pins.cstb_n = controller_addr_strobe_n;
        st_d.pins.advance_n = burst_advance_n;
        st_d.pins.gwr_n = global_write_n;
        st_d.pins.byte_wr_n = byte_write_enable_n;
        st_d.pins.lane_sel_n = byte_lane_select_n;
        st_d.pins.data = {parity_io_i, dq_i};

        // Selection tracking: a deselecting strobe or sleep ends the burst.
        if (!awake || (start && !sel)) begin
            st_d.active = 1'b0;
        end else if (load) begin
            st_d.active = 1'b1;
        end

        // Array address: external on a start, else counter-generated low bits.
        if (load) begin
            st_d.arr_addr = p.addr;
        end else begin
            st_d.arr_addr = {st_q.arr_addr[`PBSC_ADDR_W-1:`PBSC_BURST_W],
                             step ? burst_nxt : burst_cur};
        end
        // Only the chosen lanes are strobed, so the others keep their contents.
        st_d.arr_we = wr_go ? lanes : `PBSC_NO_LANES;
        st_d.arr_wdata = p.data;
        st_d.rd_issue = rd_go;

        // Read data enters the output register one edge after its address.
        if (st_q.rd_issue) begin
            st_d.dout = arr_rdata;
        end
        // Pins drive only for read data, with output enable low, and never in
        // a write, deselect or first cycle with no burst active. Output enable is resampled, so it
        // acts two edges late; the controller must raise it early.
        st_d.dq_oe_n = tristate_now || !st_q.rd_issue || st_q.oe_sync[1];

        // Sleep: two cycles to enter, two to leave, both fixed in length.
        st_d.sleep_cnt = st_q.sleep_cnt + 2'h1;
        unique case (st_q.sleep_st)
            pbsc_pkg::SLP_RUN: begin
                st_d.sleep_cnt = '0;
                if (st_q.sleep_sync[1]) begin
                    st_d.sleep_st = pbsc_pkg::SLP_ENTER;
                end
            end
            pbsc_pkg::SLP_ENTER: begin
                if (st_q.sleep_cnt == 2'(`PBSC_SLEEP_TRANSITION_CYCLES - 1)) begin
                    st_d.sleep_st = pbsc_pkg::SLP_ASLEEP;
                    st_d.low_power = 1'b1;
                end
            end
            pbsc_pkg::SLP_ASLEEP: begin
                st_d.sleep_cnt = '0;
                if (!st_q.sleep_sync[1]) begin
                    st_d.sleep_st = pbsc_pkg::SLP_EXIT;
                    st_d.low_power = 1'b0;
                end
            end
            pbsc_pkg::SLP_EXIT: begin
                // Pins are still ignored here, which the controller honours
                // by keeping selects and strobes inactive meanwhile.
                if (st_q.sleep_cnt == 2'(`PBSC_SLEEP_TRANSITION_CYCLES - 1)) begin
                    st_d.sleep_st = pbsc_pkg::SLP_RUN;
                end
            end
        endcase
    end

    // State register. Active-low pins except cs3_n and lane_sel_n, and the strap, rest at their idle levels.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.oe_sync <= `PBSC_SYNC_IDLE_HIGH;
            st_q.order_sync <= `PBSC_SYNC_IDLE_HIGH;
            st_q.pins.cs1_n <= `PBSC_PIN_IDLE_N;
            st_q.pins.pstb_n <= `PBSC_PIN_IDLE_N;
            st_q.pins.cstb_n <= `PBSC_PIN_IDLE_N;
            st_q.pins.advance_n <= `PBSC_PIN_IDLE_N;
            st_q.pins.gwr_n <= `PBSC_PIN_IDLE_N;
            st_q.pins.byte_wr_n <= `PBSC_PIN_IDLE_N;
            st_q.dq_oe_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs come straight from the state register.
    assign dq_o = st_q.dout[`PBSC_DATA_W-1:0];
    assign parity_io_o = st_q.dout[`PBSC_WORD_W-1:`PBSC_PAR_LSB];
    assign dq_oe_n = st_q.dq_oe_n;
    assign parity_io_oe_n = st_q.dq_oe_n;
    assign arr_addr = st_q.arr_addr;
    assign arr_byte_we = st_q.arr_we;
    assign arr_wdata = st_q.arr_wdata;
    assign low_power = st_q.low_power;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_pin_capture;
        1'b1 |=> p.addr == $past(addr) && p.data == $past({parity_io_i, dq_i});
    endproperty
    a_pin_capture: assert property (p_pin_capture) else $error("Pins not captured in input register.");

    property p_read_start;
        (awake && start && sel && !(cstb_go && wr_ctl)) |=> st_q.rd_issue && arr_addr == $past(p.addr);
    endproperty
    a_read_start: assert property (p_read_start) else $error("Read start not registered.");

    property p_pstb_ignored;
        (awake && !p.pstb_n && p.cs1_n && p.cstb_n && !st_q.active) |=> !st_q.rd_issue && !st_q.active;
    endproperty
    a_pstb_ignored: assert property (p_pstb_ignored) else $error("Processor strobe taken with select high.");

    property p_pstb_first_read;
        (awake && pstb_go && sel) |=> st_q.rd_issue && arr_byte_we == `PBSC_NO_LANES;
    endproperty
    a_pstb_first_read: assert property (p_pstb_first_read) else $error("Processor strobe cycle wrote.");

    // The write lands at the address that the strobe cycle captured two edges back.
    property p_pstb_write;
        (awake && pstb_go && sel) ##1 (awake && !start && wr_ctl && p.advance_n)
            |=> arr_byte_we == $past(lanes) && arr_addr == $past(p.addr, 2) && arr_wdata == $past(p.data);
    endproperty
    a_pstb_write: assert property (p_pstb_write) else $error("Second-cycle write wrong.");

    property p_cstb_write;
        (awake && cstb_go && p.pstb_n && sel && wr_ctl)
            |=> arr_byte_we == $past(lanes) && arr_addr == $past(p.addr) && !st_q.rd_issue;
    endproperty
    a_cstb_write: assert property (p_cstb_write) else $error("Controller strobe write wrong.");

    property p_global_write;
        (wr_go && !p.gwr_n) |=> arr_byte_we == `PBSC_ALL_LANES;
    endproperty
    a_global_write: assert property (p_global_write) else $error("Global write missed a lane.");

    property p_byte_write;
        (wr_go && p.gwr_n) |=> arr_byte_we == ~$past(p.lane_sel_n);
    endproperty
    a_byte_write: assert property (p_byte_write) else $error("Byte write lanes wrong.");

    property p_write_tristate;
        wr_go |=> dq_oe_n;
    endproperty
    a_write_tristate: assert property (p_write_tristate) else $error("Pins driven in a write cycle.");

    property p_deselect;
        (awake && start && !sel) |=> dq_oe_n && !st_q.active;
    endproperty
    a_deselect: assert property (p_deselect) else $error("Deselect did not tristate.");

    property p_read_drive;
        (st_q.rd_issue && !tristate_now && !st_q.oe_sync[1])
            |=> !dq_oe_n && dq_o == $past(arr_rdata[`PBSC_DATA_W-1:0]);
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("Read data not driven.");

    property p_oe_high;
        st_q.oe_sync[1] |=> dq_oe_n;
    endproperty
    a_oe_high: assert property (p_oe_high) else $error("Pins driven with output enable high.");

    property p_hold;
        (awake && st_q.active && !start && p.advance_n) |=> arr_addr == $past(arr_addr);
    endproperty
    a_hold: assert property (p_hold) else $error("Address moved while advance high.");

    property p_sleep_entry;
        (awake && st_q.sleep_sync[1]) |=> (!low_power && !awake) [*2] ##1 low_power;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("Sleep entry not two cycles.");

    property p_sleep_exit;
        (st_q.sleep_st == pbsc_pkg::SLP_ASLEEP && !st_q.sleep_sync[1]) |=> (!awake) [*2] ##1 awake;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("Sleep exit not two cycles.");

    c_pstb_read: cover property (awake && pstb_go && sel ##2 !dq_oe_n);
    c_cstb_write: cover property (awake && cstb_go && sel && wr_ctl);
    c_burst_step: cover property (step [*3]);
    c_sleep: cover property (low_power ##1 !low_power);

endmodule

// >>> testbench/pbsc_array_model.sv
// Behavioural memory array model on the array side of the burst memory control.
`timescale 1ns/1ps
`include "pbsc_defines.svh"

module pbsc_array_model (
    input wire logic clk,
    input wire logic [`PBSC_ADDR_W-1:0] arr_addr,
    input wire logic [`PBSC_LANES-1:0] arr_byte_we,
    input wire logic [`PBSC_WORD_W-1:0] arr_wdata,
    output logic [`PBSC_WORD_W-1:0] arr_rdata
);
    // Sixteen words keep the model small; upper address bits alias.
    logic [`PBSC_WORD_W-1:0] mem [0:15];

    // Known contents so that a stray read never shows an unknown.
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 36'h0;
        end
    end

    // The read is a plain look-up of the presented address.
    assign arr_rdata = mem[arr_addr[3:0]];

    // Each lane holds eight data bits and its own parity bit.
    always @(posedge clk) begin
        for (int l = 0; l < `PBSC_LANES; l++) begin
            if (arr_byte_we[l]) begin
                mem[arr_addr[3:0]][8*l +: 8] <= arr_wdata[8*l +: 8];
                mem[arr_addr[3:0]][`PBSC_PAR_LSB+l] <= arr_wdata[`PBSC_PAR_LSB+l];
            end
        end
    end
endmodule

// >>> testbench/tb_pipelined_burst_sram_control.sv
// Self-checking testbench of the pipelined burst memory control logic.
`timescale 1ns/1ps
`include "pbsc_defines.svh"

module tb_pipelined_burst_sram_control;
    logic clk, rst_n, cs1_n, cs2, cs3_n, psn, csn, advn, gwn, bwen, oen, slp, ord;
    logic [17:0] addr;
    logic [3:0] bwn, pari, par_o, we;
    logic [31:0] dqi, dq_o;
    logic dq_oe_n, par_oen, low_power;
    logic [17:0] a_addr;
    logic [35:0] wdata, rdata;
    int fails = 0;
    int checks_done = 0;

    pbsc_top i_pbsc_top (.clk(clk), .rst_n(rst_n), .addr(addr), .chip_sel1_n(cs1_n), .chip_sel2(cs2),
        .chip_sel3_n(cs3_n), .processor_addr_strobe_n(psn), .controller_addr_strobe_n(csn),
        .burst_advance_n(advn), .global_write_n(gwn), .byte_write_enable_n(bwen), .byte_lane_select_n(bwn),
        .output_enable_n(oen), .sleep_request(slp), .burst_order_sel(ord), .dq_i(dqi), .dq_o(dq_o),
        .dq_oe_n(dq_oe_n), .parity_io_i(pari), .parity_io_o(par_o), .parity_io_oe_n(par_oen), .arr_addr(a_addr),
        .arr_byte_we(we), .arr_wdata(wdata), .arr_rdata(rdata), .low_power(low_power));

    pbsc_array_model i_pbsc_array_model (.clk(clk), .arr_addr(a_addr), .arr_byte_we(we),
        .arr_wdata(wdata), .arr_rdata(rdata));

    // Free-running 50 MHz clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Every comparison goes through here so that counts stay honest.
    task automatic chk(input string nm, input logic [35:0] ex, input logic [35:0] got);
        checks_done++;
        if (got !== ex) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // Inputs always move one nanosecond after the rising edge.
    task automatic cyc();
        @(posedge clk);
        #1;
    endtask

    // Selected, no strobe, no write, no advance.
    task automatic idle();
        {cs1_n, cs2, cs3_n} = 3'h2;
        {psn, csn, advn, gwn, bwen} = 5'h1F;
        bwn = 4'hF;
    endtask

    // Output enable is raised well before any write data appears.
    task automatic cwrite(input logic [17:0] a, input logic [35:0] d);
        oen = 1'b1;
        repeat (3) cyc();
        addr = a;
        csn = 1'b0;
        gwn = 1'b0;
        {pari, dqi} = d;
        cyc();
        idle();
        cyc();
        chk("ctrl write lanes", 36'hF, 36'(we));
        chk("ctrl write addr", 36'(a), 36'(a_addr));
        chk("ctrl write data", d, wdata);
        chk("ctrl write oe", 36'h1, 36'(dq_oe_n));
    endtask

    // A strobe with the second select off deselects and releases the pins.
    task automatic desel();
        cs2 = 1'b0;
        csn = 1'b0;
        cyc();
        idle();
        cyc();
        chk("deselect oe", 36'h1, 36'(dq_oe_n));
    endtask

    // Processor-strobe read burst checked over five addresses, the fifth wrapping back to the first.
    task automatic burst(input logic [17:0] a, input logic om, input logic [35:0] d);
        logic [1:0] b;
        ord = om;
        oen = 1'b0;
        repeat (4) cyc();
        addr = a;
        psn = 1'b0;
        cyc();
        psn = 1'b1;
        advn = 1'b0;
        cyc();
        chk("first cycle oe", 36'h1, 36'(dq_oe_n));
        for (int i = 0; i < 5; i++) begin
            b = om ? (a[1:0] ^ i[1:0]) : (a[1:0] + i[1:0]);
            chk("burst addr", 36'({a[17:2], b}), 36'(a_addr));
            if (i == 1) begin
                chk("read data", d, {par_o, dq_o});
                chk("read oe", 36'h0, 36'(dq_oe_n));
                chk("read parity oe", 36'h0, 36'(par_oen));
            end
            cyc();
        end
        idle();
    endtask

    // Processor-strobe write; both strobes and global write low in the first cycle.
    task automatic pwrite(input logic [17:0] a, input logic [3:0] ln, input logic [35:0] d);
        addr = a;
        psn = 1'b0;
        csn = 1'b0;
        gwn = 1'b0;
        cyc();
        {psn, csn, gwn} = 3'h7;
        bwen = 1'b0;
        bwn = ln;
        {pari, dqi} = d;
        cyc();
        chk("first cycle no write", 36'h0, 36'(we));
        idle();
        cyc();
        chk("byte write lanes", {32'h0, ~ln}, 36'(we));
        chk("byte write addr", 36'(a), 36'(a_addr));
        chk("byte write data", d, wdata);
        chk("byte write oe", 36'h1, 36'(dq_oe_n));
        cyc();
    endtask

    // Processor strobe with the first select high must start nothing.
    task automatic ignore_cs1();
        logic [17:0] old;
        // Deselected first, so that no running burst can mask a wrongly taken strobe.
        desel();
        old = a_addr;
        cs1_n = 1'b1;
        psn = 1'b0;
        addr = 18'h3FFFF;
        cyc();
        idle();
        cyc();
        chk("ignored strobe addr", 36'(old), 36'(a_addr));
        chk("ignored strobe lanes", 36'h0, 36'(we));
        chk("ignored strobe oe", 36'h1, 36'(dq_oe_n));
    endtask

    // Deselect, sleep, wake, and stay idle through recovery.
    task automatic sleep_seq();
        desel();
        // All selects stay inactive through sleep and recovery.
        {cs1_n, cs2, cs3_n} = 3'h5;
        slp = 1'b1;
        repeat (4) cyc();
        chk("sleep not yet", 36'h0, 36'(low_power));
        cyc();
        chk("asleep", 36'h1, 36'(low_power));
        slp = 1'b0;
        repeat (2) cyc();
        chk("still asleep", 36'h1, 36'(low_power));
        cyc();
        chk("awake", 36'h0, 36'(low_power));
        repeat (4) cyc();
    endtask

    // Single place where the run ends.
    task automatic finish_test();
        if (fails == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Cuts a hang short well after the expected run of about eighty cycles.
    initial begin
        #100000;
        fails++;
        finish_test();
    end

    // Main sequence.
    initial begin
        rst_n = 1'b0;
        idle();
        {addr, dqi, pari, slp} = '0;
        oen = 1'b1;
        ord = 1'b1;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        cwrite(18'h00103, 36'h9DEADBEEF);
        desel();
        burst(18'h00103, 1'b0, 36'h9DEADBEEF);
        cwrite(18'h00101, 36'h512345678);
        desel();
        burst(18'h00101, 1'b1, 36'h512345678);
        cwrite(18'h00105, 36'hFFFFFFFFF);
        pwrite(18'h00105, 4'hA, 36'h0A1B2C3D4);
        chk("lanes kept", 36'hAFFB2FFD4, i_pbsc_array_model.mem[5]);
        ignore_cs1();
        sleep_seq();
        finish_test();
    end
endmodule
